// [hw/lpm_pkg.sv]
package lpm_pkg;
  // ==========================================================
  // Power state encoding (Gray along run->suspend->standby->off)
  typedef enum logic [1:0] {
    LPM_RUN = 2'h0,
    LPM_SUSPEND = 2'h1,
    LPM_STANDBY = 2'h3,
    LPM_CORE_OFF = 2'h2
  } lpm_state_t;

  // Requested mode codes on the mode bus
  localparam logic [1:0] LPM_REQ_NONE = 2'h0;
  localparam logic [1:0] LPM_REQ_SUSPEND = 2'h1;
  localparam logic [1:0] LPM_REQ_STANDBY = 2'h2;
  localparam logic [1:0] LPM_REQ_CORE_OFF = 2'h3;

  // ==========================================================
  // Pad configuration codes
  localparam logic [1:0] LPM_PAD_HIZ = 2'h0;
  localparam logic [1:0] LPM_PAD_PULLUP = 2'h1;
  localparam logic [1:0] LPM_PAD_PULLDOWN = 2'h2;
  localparam logic [1:0] LPM_DRIVE_FULL = 2'h3;
  localparam logic [1:0] LPM_DRIVE_QUARTER = 2'h0;

  // Wake source bit positions
  localparam int LPM_WK_DP = 0;
  localparam int LPM_WK_DM = 1;
  localparam int LPM_WK_OTG = 2;
  localparam int LPM_WK_SUPERSPEED_RX_POS = 3;
  localparam int LPM_WK_VBUS = 4;
  localparam int LPM_WK_CTS = 5;
  localparam int LPM_WK_CTL0 = 6;
  localparam int LPM_WK_BITS = 7;

  // Standby only honours bus power, clear-to-send and control pin 0
  localparam logic [6:0] LPM_STANDBY_WAKE_MASK = 7'h70;
  localparam logic [6:0] LPM_SUSPEND_WAKE_MASK = 7'h7f;

  // Synchroniser depth and restart hold after wake
  localparam int LPM_SYNC_STAGES = 2;
  localparam logic [3:0] LPM_RESTART_CYCLES = 4'h4;
  localparam logic [1:0] LPM_RESET_VALUE = 2'h0;
endpackage : lpm_pkg

// [hw/lpm_if.sv]
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Link between power controller and its requester
interface lpm_if;
  logic [1:0] req_mode;
  logic req_valid;
  logic req_idle;
  logic [1:0] cur_state;
  logic req_ack;
  logic wake_pulse;
  logic pc_reset;

  modport device (
    input req_mode, req_valid, req_idle,
    output cur_state, req_ack, wake_pulse, pc_reset
  );
  modport host (
    output req_mode, req_valid, req_idle,
    input cur_state, req_ack, wake_pulse, pc_reset
  );
endinterface : lpm_if
`default_nettype wire

// [hw/lpm_host.sv]
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Requester end: firmware or external processor side
module lpm_host
  import lpm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [1:0] i_mode,
  input wire logic i_xfer_busy,
  input wire logic i_buf_drained,
  output logic o_busy,
  output logic o_woke,
  output logic o_pc_reset,
  lpm_if.host link
);
  logic pending;
  logic [1:0] mode_q;

  // ==========================================================
  // Hold a request until acknowledged; it goes out once transfers finish (standby also waits for drained buffers).
  // A none code is dropped here: the controller would never acknowledge it.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pending <= 1'b0;
      mode_q <= LPM_REQ_NONE;
    end else if (link.req_ack) begin
      pending <= 1'b0;
    end else if (i_go && !pending && i_mode != LPM_REQ_NONE) begin
      pending <= 1'b1;
      mode_q <= i_mode;
    end
  end

  // Request only while idle; standby also waits for drained buffers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.req_valid <= 1'b0;
      link.req_mode <= LPM_REQ_NONE;
      link.req_idle <= 1'b0;
    end else begin
      link.req_valid <= pending && !link.req_ack && !i_xfer_busy
        && (mode_q != LPM_REQ_STANDBY || i_buf_drained);
      link.req_mode <= mode_q;
      link.req_idle <= !i_xfer_busy;
    end
  end

  // Status seen by the local user
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_woke <= 1'b0;
      o_pc_reset <= 1'b0;
    end else begin
      o_busy <= pending;
      o_woke <= link.wake_pulse;
      o_pc_reset <= link.pc_reset;
    end
  end
endmodule : lpm_host
`default_nettype wire

// [hw/lpm_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int N_PINS = 8,
  parameter int N_IFACE = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_usb_dp,
  input wire logic i_usb_dm,
  input wire logic i_otg_ident_change,
  input wire logic i_superspeed_rx_pos_resume,
  input wire logic i_vbus_detect,
  input wire logic i_uart_cts,
  input wire logic i_cts_active_high,
  input wire logic i_iface_ctrl_pin0,
  input wire logic [N_PINS-1:0] i_pin_out,
  input wire logic [N_PINS-1:0] i_pin_oe_n,
  input wire logic [2*N_PINS-1:0] i_pin_pull_cfg,
  input wire logic [2*N_IFACE-1:0] i_drive_cfg,
  output logic [N_PINS-1:0] o_pad_out,
  output logic [N_PINS-1:0] o_pad_oe_n,
  output logic [2*N_PINS-1:0] o_pad_pull,
  output logic [2*N_IFACE-1:0] o_pad_drive,
  output logic o_ss_phy_en,
  output logic o_usb_suspend,
  output logic o_usb_xcvr_en,
  output logic o_clk_gate_en,
  output logic o_pll_en,
  output logic o_xtal_en,
  output logic o_core_pwr_en,
  output logic o_buf_retain,
  output logic o_cfg_retain,
  lpm_if.device link
);
  lpm_state_t state;
  lpm_state_t next_state;
  logic [LPM_WK_BITS-1:0] wake_raw;
  logic [LPM_WK_BITS-1:0] wake_latch;
  logic [LPM_WK_BITS-1:0] wake_sync1;
  logic [LPM_WK_BITS-1:0] wake_sync2;
  logic dp_prev;
  logic dm_prev;
  logic wake_hit;
  logic [3:0] restart_cnt;
  logic low_power;

  // ==========================================================
  // Wake source decode
  function automatic logic [LPM_WK_BITS-1:0] wake_mask(input lpm_state_t s);
    case (s)
      LPM_SUSPEND: wake_mask = LPM_SUSPEND_WAKE_MASK;
      LPM_STANDBY: wake_mask = LPM_STANDBY_WAKE_MASK;
      default: wake_mask = '0;
    endcase
  endfunction : wake_mask

  // Raw events; line transitions compare with value held at entry
  always_comb begin
    wake_raw = '0;
    wake_raw[LPM_WK_DP] = i_usb_dp != dp_prev;
    wake_raw[LPM_WK_DM] = i_usb_dm != dm_prev;
    wake_raw[LPM_WK_OTG] = i_otg_ident_change;
    wake_raw[LPM_WK_SUPERSPEED_RX_POS] = i_superspeed_rx_pos_resume;
    wake_raw[LPM_WK_VBUS] = i_vbus_detect;
    wake_raw[LPM_WK_CTS] = i_uart_cts == i_cts_active_high;
    wake_raw[LPM_WK_CTL0] = i_iface_ctrl_pin0;
  end

  // ==========================================================
  // Latch stands in for the clockless detector: it captures the
  // event, then a two-stage synchroniser hands it to the restarted
  // clock, so a glitch shorter than the restart is never lost.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_latch <= '0;
    end else if (!low_power) begin
      wake_latch <= '0;
    end else begin
      wake_latch <= wake_latch | (wake_raw & wake_mask(state));
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_sync1 <= '0;
      wake_sync2 <= '0;
    end else begin
      wake_sync1 <= wake_latch;
      wake_sync2 <= wake_sync1;
    end
  end

  assign wake_hit = |wake_sync2;
  assign low_power = state == LPM_SUSPEND || state == LPM_STANDBY;

  // Line levels captured at entry for transition detection
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dp_prev <= 1'b0;
      dm_prev <= 1'b0;
    end else if (!low_power) begin
      dp_prev <= i_usb_dp;
      dm_prev <= i_usb_dm;
    end
  end

  // ==========================================================
  // State machine; wake exits suspend and standby, reset is the only exit from core off
  always_comb begin
    next_state = state;
    case (state)
      LPM_RUN: begin
        if (link.req_valid && link.req_idle) begin
          case (link.req_mode)
            LPM_REQ_SUSPEND: next_state = LPM_SUSPEND;
            LPM_REQ_STANDBY: next_state = LPM_STANDBY;
            LPM_REQ_CORE_OFF: next_state = LPM_CORE_OFF;
            default: next_state = LPM_RUN;
          endcase
        end
      end
      LPM_SUSPEND: if (wake_hit) next_state = LPM_RUN;
      LPM_STANDBY: if (wake_hit) next_state = LPM_RUN;
      LPM_CORE_OFF: next_state = LPM_CORE_OFF;
      default: next_state = LPM_RUN;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= LPM_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Core restart hold after standby; suspend exit keeps the PC
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      restart_cnt <= '0;
    end else if (state == LPM_STANDBY && wake_hit) begin
      restart_cnt <= LPM_RESTART_CYCLES;
    end else if (restart_cnt != '0) begin
      restart_cnt <= restart_cnt - 4'h1;
    end
  end

  // ==========================================================
  // Handshake outputs to requester
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.cur_state <= LPM_RESET_VALUE;
      link.req_ack <= 1'b0;
      link.wake_pulse <= 1'b0;
      link.pc_reset <= 1'b0;
    end else begin
      link.cur_state <= next_state;
      link.req_ack <= state == LPM_RUN && next_state != LPM_RUN;
      link.wake_pulse <= low_power && wake_hit;
      link.pc_reset <= (state == LPM_STANDBY && wake_hit) || restart_cnt > 4'h1;
    end
  end

  // ==========================================================
  // Power and clock controls, registered from next state
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ss_phy_en <= 1'b1;
      o_usb_suspend <= 1'b0;
      o_usb_xcvr_en <= 1'b1;
      o_clk_gate_en <= 1'b1;
      o_pll_en <= 1'b1;
      o_xtal_en <= 1'b1;
      o_core_pwr_en <= 1'b1;
      o_buf_retain <= 1'b1;
      o_cfg_retain <= 1'b1;
    end else begin
      o_ss_phy_en <= next_state == LPM_RUN;
      o_usb_suspend <= next_state != LPM_RUN;
      o_clk_gate_en <= next_state == LPM_RUN;
      o_pll_en <= next_state == LPM_RUN;
      o_xtal_en <= next_state == LPM_RUN || next_state == LPM_SUSPEND;
      o_usb_xcvr_en <= next_state == LPM_RUN || next_state == LPM_SUSPEND;
      o_core_pwr_en <= next_state == LPM_RUN || next_state == LPM_SUSPEND;
      // Buffers survive suspend only; config survives both low states
      o_buf_retain <= next_state != LPM_STANDBY && next_state != LPM_CORE_OFF;
      o_cfg_retain <= next_state != LPM_CORE_OFF;
    end
  end

  // ==========================================================
  // Pads follow core values in run, freeze while low power.
  // Config is also frozen so a stray write cannot change pulls.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad_out <= '0;
      o_pad_oe_n <= '1;
      o_pad_pull <= '0;
      o_pad_drive <= {N_IFACE{LPM_DRIVE_FULL}};
    end else if (next_state == LPM_RUN) begin
      o_pad_out <= i_pin_out;
      o_pad_oe_n <= i_pin_oe_n;
      o_pad_pull <= i_pin_pull_cfg;
      o_pad_drive <= i_drive_cfg;
    end else begin
      o_pad_out <= o_pad_out;
      o_pad_oe_n <= o_pad_oe_n;
      o_pad_pull <= o_pad_pull;
      o_pad_drive <= o_pad_drive;
    end
  end
endmodule : lpm_ctrl
`default_nettype wire

// [tb/lpm_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Link checker between requester and power controller
module lpm_monitor
  import lpm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_req_mode,
  input wire logic i_req_valid,
  input wire logic i_req_idle,
  input wire logic [1:0] i_cur_state,
  input wire logic i_req_ack,
  input wire logic i_wake_pulse,
  input wire logic i_pc_reset
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // A request counts only in run with no transfer pending
  logic take;
  assign take = i_cur_state == LPM_RUN && i_req_valid && i_req_idle;

  AST_SUSP_TAKE: assert property (take && i_req_mode == LPM_REQ_SUSPEND
    |=> i_req_ack && i_cur_state == LPM_SUSPEND)
    else $error("suspend not taken");
  AST_STBY_TAKE: assert property (take && i_req_mode == LPM_REQ_STANDBY
    |=> i_req_ack && i_cur_state == LPM_STANDBY)
    else $error("standby not taken");
  AST_OFF_TAKE: assert property (take && i_req_mode == LPM_REQ_CORE_OFF
    |=> i_req_ack && i_cur_state == LPM_CORE_OFF)
    else $error("core off not taken");
  // Any run cycle without a full idle request must not be acknowledged
  AST_BUSY_REFUSED: assert property (i_cur_state == LPM_RUN && !(i_req_valid && i_req_idle)
    |=> !i_req_ack)
    else $error("taken while busy");
  AST_LOW_REFUSED: assert property (i_cur_state != LPM_RUN |=> !i_req_ack)
    else $error("taken in low power");
  AST_ACK_ONCE: assert property (i_req_ack |=> !i_req_ack && !i_req_valid)
    else $error("ack not a pulse");
  AST_WAKE_EXIT: assert property (i_wake_pulse
    |-> i_cur_state == LPM_RUN && $past(i_cur_state) inside {LPM_SUSPEND, LPM_STANDBY})
    else $error("wake without exit");
  AST_OFF_HOLD: assert property (i_cur_state == LPM_CORE_OFF |=> i_cur_state == LPM_CORE_OFF)
    else $error("core off left");
  AST_STBY_PC: assert property (i_wake_pulse && $past(i_cur_state) == LPM_STANDBY
    |-> i_pc_reset [*4] ##1 !i_pc_reset)
    else $error("no restart hold");
  AST_SUSP_PC: assert property (i_wake_pulse && $past(i_cur_state) == LPM_SUSPEND |-> !i_pc_reset [*2])
    else $error("counter reset");
endmodule : lpm_monitor
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Both ends joined; user sides driven here
module testbench;
  import lpm_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, go = 1'h0, busy = 1'h0, drained = 1'h1, cts_hi = 1'h1;
  logic [1:0] mode = 2'h0;
  logic [6:0] wk = 7'h00;
  logic [7:0] pin_out = 8'h00, oe_n = 8'h0f, pad_out, pad_oe_n;
  logic [15:0] pull = 16'h0024;
  logic [3:0] drv = 4'hf, pad_drv;
  logic [15:0] pad_pull;
  logic pc_out, phy, susp, xcvr, cg, pll, xtal, core, bret, cret, pend, woke;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  lpm_if lnk();

  lpm_host lpm_host_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_mode(mode), .i_xfer_busy(busy),
    .i_buf_drained(drained), .o_busy(pend), .o_woke(woke), .o_pc_reset(pc_out), .link(lnk));
  lpm_ctrl lpm_ctrl_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_usb_dp(wk[0]), .i_usb_dm(wk[1]),
    .i_otg_ident_change(wk[2]), .i_superspeed_rx_pos_resume(wk[3]), .i_vbus_detect(wk[4]),
    .i_uart_cts(wk[5] ~^ cts_hi), .i_cts_active_high(cts_hi), .i_iface_ctrl_pin0(wk[6]),
    .i_pin_out(pin_out), .i_pin_oe_n(oe_n), .i_pin_pull_cfg(pull), .i_drive_cfg(drv),
    .o_pad_out(pad_out), .o_pad_oe_n(pad_oe_n), .o_pad_pull(pad_pull), .o_pad_drive(pad_drv),
    .o_ss_phy_en(phy), .o_usb_suspend(susp), .o_usb_xcvr_en(xcvr), .o_clk_gate_en(cg), .o_pll_en(pll),
    .o_xtal_en(xtal), .o_core_pwr_en(core), .o_buf_retain(bret), .o_cfg_retain(cret), .link(lnk));
  lpm_monitor lpm_monitor_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_req_mode(lnk.req_mode),
    .i_req_valid(lnk.req_valid), .i_req_idle(lnk.req_idle), .i_cur_state(lnk.cur_state),
    .i_req_ack(lnk.req_ack), .i_wake_pulse(lnk.wake_pulse), .i_pc_reset(lnk.pc_reset));

  // 50 MHz clock
  always #10 clk = ~clk;

  // Hang guard; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ============================================================
  // Tasks
  task chk(input logic [15:0] g, input logic [15:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk

  task give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // One-cycle go pulse; the host only takes it with no request pending
  task request(input logic [1:0] m);
    @(posedge clk);
    go <= 1'h1;
    mode <= m;
    @(posedge clk);
    go <= 1'h0;
  endtask : request

  // Ack is a one-cycle pulse, so sample every negedge
  task wack(input logic e);
    repeat (10) begin
      @(negedge clk);
      if (lnk.req_ack === 1'h1) break;
    end
    chk(lnk.req_ack, e, "ack");
  endtask : wack

  task wake(input int b, input logic pc);
    @(posedge clk);
    wk[b] <= 1'h1;
    repeat (10) begin
      @(negedge clk);
      if (lnk.wake_pulse === 1'h1) break;
    end
    chk(lnk.wake_pulse, 1'h1, "wake");
    chk(lnk.cur_state, LPM_RUN, "run");
    @(negedge clk);
    chk(lnk.pc_reset, pc, "pc");
    chk(woke, 1'h1, "host woke");
    @(negedge clk);
    chk(pc_out, pc, "host pc");
    @(posedge clk);
    wk <= 7'h00;
    repeat (6) @(posedge clk);
  endtask : wake

  // ============================================================
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    chk({pad_out, pad_drv, 4'h0}, 16'h00f0, "rst pads");
    chk({phy, susp, xcvr, cg, pll, xtal, core, bret, cret}, 9'h17f, "rst en");
    chk(pad_oe_n, 8'hff, "rst oe");
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    $display("test reset done");
    for (int d = 0; d < 4; d++) begin
      @(posedge clk);
      drv <= {2'(3 - d), 2'(d)};
      repeat (2) @(negedge clk);
      chk(pad_drv, {2'(3 - d), 2'(d)}, "drive");
    end
    chk(pad_pull, 16'h0024, "pull");
    chk(pad_oe_n, 8'h0f, "oe run");
    request(LPM_REQ_NONE);
    wack(1'h0);
    chk(pend, 1'h0, "none dropped");
    $display("test pads done");
    for (int b = 0; b < 7; b++) begin
      @(posedge clk);
      pin_out <= 8'h5a;
      oe_n <= 8'h0f;
      request(LPM_REQ_SUSPEND);
      wack(1'h1);
      chk({phy, susp, cg, pll, bret, cret}, 6'h13, "susp en");
      @(posedge clk);
      pin_out <= 8'ha5;
      oe_n <= 8'hf0;
      repeat (2) @(negedge clk);
      chk(pad_out, 8'h5a, "hold");
      chk(pad_oe_n, 8'h0f, "oe hold");
      wake(b, 1'h0);
    end
    cts_hi <= 1'h0;
    request(LPM_REQ_SUSPEND);
    wack(1'h1);
    wake(5, 1'h0);
    $display("test suspend done");
    busy <= 1'h1;
    request(LPM_REQ_SUSPEND);
    wack(1'h0);
    chk(pend, 1'h1, "pending");
    @(posedge clk);
    busy <= 1'h0;
    wack(1'h1);
    wake(6, 1'h0);
    $display("test busy done");
    for (int i = 4; i < 7; i++) begin
      drained <= 1'(i > 4);
      request(LPM_REQ_STANDBY);
      if (i == 4) begin
        wack(1'h0);
        @(posedge clk);
        drained <= 1'h1;
      end
      wack(1'h1);
      chk({xcvr, pll, xtal, core, cret}, 5'h01, "stby en");
      @(posedge clk);
      wk[0] <= 1'h1;
      pin_out <= 8'h3c;
      repeat (8) @(negedge clk);
      chk(lnk.cur_state, LPM_STANDBY, "dp ignored");
      chk(pad_out, 8'ha5, "pins kept");
      @(posedge clk);
      wk <= 7'h00;
      // Restore the entry value so each pass freezes the same pins
      pin_out <= 8'ha5;
      wake(i, 1'h1);
    end
    $display("test standby done");
    request(LPM_REQ_CORE_OFF);
    wack(1'h1);
    chk({core, bret, cret}, 3'h0, "off en");
    @(posedge clk);
    wk[4] <= 1'h1;
    repeat (8) @(negedge clk);
    chk(lnk.cur_state, LPM_CORE_OFF, "off held");
    @(posedge clk);
    rst_n <= 1'h0;
    wk <= 7'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    chk(lnk.cur_state, LPM_RUN, "reset exit");
    chk({phy, susp, xcvr, cg, pll, xtal, core, bret, cret}, 9'h17f, "reset en");
    $display("test core off done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
